/* File: dv/pss_board.sv */
/* Board model: supplies, reset pin, straps, reference clock.
   Assumes tasks are called from clk_sys falling edges. */
`default_nettype none
module pss_board (
  input wire logic clk_sys,
  output logic [2:0] supply_good,
  output logic hw_reset_n,
  output logic crystal_input_pin,
  output logic [pss_pkg::STRAP_W-1:0] strap_pins,
  output logic rmii_phase
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    supply_good = 3'h0;
    hw_reset_n = 1'h1;
    strap_pins = 8'h5a;
    crystal_input_pin = 1'h0;
    rmii_phase = 1'h0;
  end
  // Reference from clk_sys, so the MAC side stays synchronous
  always @(negedge clk_sys) begin
    crystal_input_pin <= ~crystal_input_pin;
    rmii_phase <= ~rmii_phase;
  end
  // One supply changes; no order is imposed
  task automatic rail(input int i, input logic v);
    @(negedge clk_sys);
    supply_good[i] = v;
  endtask
  // Reset pulse; straps move only while it is held
  task automatic pulse(input int n, input logic [pss_pkg::STRAP_W-1:0] s);
    @(negedge clk_sys);
    hw_reset_n = 1'h0;
    strap_pins = s;
    repeat (n) @(negedge clk_sys);
    hw_reset_n = 1'h1;
  endtask
endmodule
`default_nettype wire

/* File: dv/pss_properties.sv */
/* Port checker for the start-up sequencer.
   Assumes the bind hands on the shortened power-good count. */
`default_nettype none
module pss_properties #(
  parameter int PGOOD_CYCLES = 20
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [2:0] supply_good,
  input wire logic [pss_pkg::STRAP_W-1:0] strap_pins,
  input wire logic tx_fifo_depth_unit_in,
  input wire logic tx_fifo_depth_unit_we,
  input wire logic link_up,
  input wire logic power_good,
  input wire logic clock_settled,
  input wire logic strap_valid,
  input wire logic [pss_pkg::STRAP_W-1:0] strap_cfg,
  input wire logic mgmt_enable,
  input wire logic tx_fifo_depth_unit,
  input wire logic rmii_phase_held
);
  timeunit 1ns;
  timeprecision 1ns;
  int good_cnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // Cycles with every supply up; any drop starts over
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n)
      good_cnt <= 0;
    else
      good_cnt <= (&supply_good) ? good_cnt + 1 : 0;
  end
  pg_drop_a: assert property (!(&supply_good) |-> ##[1:4] !power_good)
    else $error("power good kept");
  pg_delay_a: assert property ($rose(power_good) |->
    good_cnt inside {[PGOOD_CYCLES + 1:PGOOD_CYCLES + 6]}) else $error("power good delay");
  settle_order_a: assert property (clock_settled |-> power_good)
    else $error("settled early");
  strap_latch_a: assert property ($rose(clock_settled) |-> ##[0:2] strap_valid)
    else $error("straps late");
  strap_value_a: assert property ($rose(strap_valid) |-> strap_cfg == strap_pins)
    else $error("strap value");
  mgmt_order_a: assert property (mgmt_enable |-> strap_valid && clock_settled)
    else $error("mgmt early");
  mgmt_soon_a: assert property ($rose(strap_valid) |-> ##[1:4] mgmt_enable)
    else $error("mgmt late");
  depth_write_a: assert property (tx_fifo_depth_unit_we |=>
    tx_fifo_depth_unit == $past(tx_fifo_depth_unit_in)) else $error("depth write");
  phase_freeze_a: assert property ($past(link_up) |-> $stable(rmii_phase_held))
    else $error("phase moved");
  c_ready: cover property ($rose(mgmt_enable));
  c_nibble: cover property (tx_fifo_depth_unit_we && !tx_fifo_depth_unit_in);
  c_link: cover property (link_up && power_good);
endmodule
bind pss_top pss_properties #(.PGOOD_CYCLES(PGOOD_CYCLES)) chk_i (.clk_sys, .arst_n,
  .supply_good, .strap_pins, .tx_fifo_depth_unit_in, .tx_fifo_depth_unit_we, .link_up,
  .power_good, .clock_settled, .strap_valid, .strap_cfg, .mgmt_enable,
  .tx_fifo_depth_unit, .rmii_phase_held);
`default_nettype wire

/* File: dv/test_phy_startup_and_tx_fifo_setup.sv */
/* Bench for the start-up sequencer and FIFO setup.
   Assumes the board model drives the pins and the checker is bound. */
`default_nettype none
module test_phy_startup_and_tx_fifo_setup;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PG = 20, XT = 10, EX = 5, RL = 4;
  logic clk_sys = 1'h0, arst_n = 1'h0, d_in = 1'h0, d_we = 1'h0, s_in = 1'h0;
  logic s_we = 1'h0, nib = 1'h0, rmii = 1'h0, link = 1'h0, hr, xi, rp, b;
  logic pg, cs, sv, me, du, fs, ph;
  logic [2:0] sg;
  logic [7:0] sp, cfg;
  logic [1:0] pf;
  int mismatches = 0, num_checks = 0, n;
  // Depth in, sync in, nibble, rmii; then depth, sync, prefill
  logic [7:0] rows [4] = '{8'hcc, 8'haa, 8'h65, 8'h13};
  always #4 clk_sys = ~clk_sys;
  pss_board board (.clk_sys(clk_sys), .supply_good(sg), .hw_reset_n(hr),
    .crystal_input_pin(xi), .strap_pins(sp), .rmii_phase(rp));
  pss_top #(.PGOOD_CYCLES(PG), .XTAL_CYCLES(XT), .EXTCLK_CYCLES(EX), .MGMT_CYCLES(1000),
    .RESET_LOW_CYCLES(RL)) dut (.clk_sys(clk_sys), .arst_n(arst_n), .supply_good(sg),
    .hw_reset_n(hr), .crystal_input_pin(xi), .strap_pins(sp), .tx_fifo_depth_unit_in(d_in),
    .tx_fifo_depth_unit_we(d_we), .tx_fifo_sync_in(s_in), .tx_fifo_sync_we(s_we),
    .mii_nibble_mode(nib), .rmii_mode(rmii), .link_up(link), .rmii_phase(rp),
    .power_good(pg), .clock_settled(cs), .strap_valid(sv), .strap_cfg(cfg),
    .mgmt_enable(me), .tx_fifo_depth_unit(du), .tx_fifo_sync(fs), .tx_prefill_sel(pf),
    .rmii_phase_held(ph));
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'h1) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // Bounded wait on a level; n holds the cycles taken
  task automatic upto(ref logic s, input int lim);
    n = 0;
    while (s !== 1'h1 && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Hang guard, far beyond the hundred or so cycles needed
  initial begin
    #20000;
    mismatches++;
    results();
  end
  initial begin
    repeat (3) @(negedge clk_sys);
    arst_n = 1'h1;
    chk(du === 1'h1 && fs === 1'h0 && pg === 1'h0, "reset values");
    board.rail(2, 1'h1);
    board.rail(1, 1'h1);
    board.rail(0, 1'h1);
    repeat (5) @(negedge clk_sys);
    // Drop mid-count: the delay must restart from the last riser
    board.rail(0, 1'h0);
    chk(pg === 1'h0, "early power good");
    board.rail(0, 1'h1);
    upto(pg, 40);
    chk(n >= PG && n <= PG + 6, "power good delay");
    upto(cs, 40);
    chk(n >= XT - 1 && n <= XT + 3, "crystal settle");
    upto(me, 20);
    chk(sv === 1'h1 && cfg === 8'h5a && n <= 8, "strap capture");
    foreach (rows[i]) begin
      {d_in, s_in, nib, rmii} = rows[i][7:4];
      d_we = 1'h1;
      s_we = 1'h1;
      @(negedge clk_sys);
      d_we = 1'h0;
      s_we = 1'h0;
      @(negedge clk_sys);
      chk({du, fs, pf} === rows[i][3:0], "config row");
    end
    board.pulse(2, 8'h5a);
    repeat (4) @(negedge clk_sys);
    chk(me === 1'h1 && du === 1'h0, "short reset");
    board.pulse(RL + 4, 8'ha5);
    chk(me === 1'h0 && du === 1'h1, "reset held");
    upto(cs, 20);
    chk(n <= EX + 5, "external settle");
    upto(me, 20);
    chk(cfg === 8'ha5 && me === 1'h1, "straps after reset");
    b = ph;
    @(negedge clk_sys);
    chk(ph !== b, "phase tracks");
    link = 1'h1;
    repeat (2) @(negedge clk_sys);
    b = ph;
    repeat (5) @(negedge clk_sys);
    chk(ph === b, "phase held");
    board.rail(1, 1'h0);
    repeat (5) @(negedge clk_sys);
    chk(pg === 1'h0 && me === 1'h0, "brown out");
    results();
  end
endmodule
`default_nettype wire

/* File: rtl/pss_pkg.sv */
/*
  Package for the PHY start-up sequencer: timing figures, derived cycle
  counts, reset values and state encoding.
  Assumes a 125 MHz system clock.
*/
`default_nettype none
package pss_pkg;
  localparam int CLK_MHZ = 125;
  // Times, all in microseconds
  localparam int PGOOD_DELAY_US = 6800;
  localparam int XTAL_SETTLE_US = 2000;
  localparam int EXTCLK_SETTLE_US = 20;
  localparam int STRAP_LATCH_US = 64;
  localparam int RESET_LOW_MIN_US = 10;
  localparam int MGMT_ACTIVE_US = 5000;
  // Derived cycle counts; whole microseconds times CLK_MHZ, so none needs rounding
  localparam int PGOOD_CYC = PGOOD_DELAY_US * CLK_MHZ;
  localparam int XTAL_CYC = XTAL_SETTLE_US * CLK_MHZ;
  localparam int EXTCLK_CYC = EXTCLK_SETTLE_US * CLK_MHZ;
  localparam int STRAP_CYC = STRAP_LATCH_US * CLK_MHZ;
  localparam int RESET_LOW_CYC = RESET_LOW_MIN_US * CLK_MHZ;
  localparam int MGMT_CYC = MGMT_ACTIVE_US * CLK_MHZ;
  localparam int CNT_W = 20;
  localparam int STRAP_W = 8;
  // Reset values and prefill encodings
  localparam logic DEPTH_UNIT_RST = 1'h1;
  localparam logic [STRAP_W-1:0] STRAP_RST = 8'h00;
  localparam logic [1:0] PREFILL_NIBBLE = 2'h1;
  localparam logic [1:0] PREFILL_BYTE = 2'h2;
  localparam logic [1:0] PREFILL_RMII = 2'h3;
  localparam logic [1:0] PREFILL_NONE = 2'h0;

  typedef enum logic [2:0] {
    ST_POR = 3'h0,
    ST_PGOOD_WAIT = 3'h1,
    ST_CLK_SETTLE = 3'h2,
    ST_STRAP = 3'h3,
    ST_MGMT_WAIT = 3'h4,
    ST_READY = 3'h5
  } pss_state_type;
endpackage
`default_nettype wire

/* File: rtl/pss_sync.sv */
/*
  Two-flop synchroniser bank for asynchronous pin inputs.
  Assumes the destination is clk_sys.
*/
`default_nettype none
module pss_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage is read only by the second
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end
  assign dout = sync_q;
endmodule
`default_nettype wire

/* File: rtl/pss_top.sv */
/*
  PHY start-up sequencer with transmit FIFO setup outputs.
  Assumes supply-good, reset and strap pins are asynchronous to clk_sys
  and are synchronised here; everything else runs on clk_sys.
*/
// Functional notes
// - Internal power good rises a fixed 6.8 ms after the last supply is good.
// - Supplies may come up in any order; the delay restarts from the last one.
// - After power good wait up to 2 ms (crystal) or 20 us (external clock).
// - Straps are captured within 64 us of clock settle, on power-up and reset.
// - A depth-unit bit chooses bytes or nibbles for MII, resetting to bytes.
// - Byte counting in nibble MII modes selects a larger prefill.
// - In asynchronous FIFO mode the FIFO absorbs any phase difference.
// - RMII latency depends on clock phase but is fixed for a link's lifetime.
`default_nettype none
module pss_top #(
  parameter int PGOOD_CYCLES = pss_pkg::PGOOD_CYC,
  parameter int XTAL_CYCLES = pss_pkg::XTAL_CYC,
  parameter int EXTCLK_CYCLES = pss_pkg::EXTCLK_CYC,
  parameter int MGMT_CYCLES = pss_pkg::MGMT_CYC,
  parameter int RESET_LOW_CYCLES = pss_pkg::RESET_LOW_CYC
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [2:0] supply_good,
  input wire logic hw_reset_n,
  input wire logic crystal_input_pin,
  input wire logic [pss_pkg::STRAP_W-1:0] strap_pins,
  input wire logic tx_fifo_depth_unit_in,
  input wire logic tx_fifo_depth_unit_we,
  input wire logic tx_fifo_sync_in,
  input wire logic tx_fifo_sync_we,
  input wire logic mii_nibble_mode,
  input wire logic rmii_mode,
  input wire logic link_up,
  input wire logic rmii_phase,
  output logic power_good,
  output logic clock_settled,
  output logic strap_valid,
  output logic [pss_pkg::STRAP_W-1:0] strap_cfg,
  output logic mgmt_enable,
  output logic tx_fifo_depth_unit,
  output logic tx_fifo_sync,
  output logic [1:0] tx_prefill_sel,
  output logic rmii_phase_held
);
  localparam int SW = pss_pkg::STRAP_W + 6;
  logic [SW-1:0] pin_s;
  logic [2:0] sup_s;
  logic rst_s;
  logic xtal_s;
  logic [pss_pkg::STRAP_W-1:0] strap_s;
  logic ext_s;
  logic rphase_s;

  // Pins cross into clk_sys through two flops
  pss_sync #(.W(SW)) u_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .din({supply_good, hw_reset_n, crystal_input_pin, rmii_phase, strap_pins}),
    .dout(pin_s)
  );
  assign sup_s = pin_s[SW-1 -: 3];
  assign rst_s = pin_s[SW-4];
  assign xtal_s = pin_s[SW-5];
  assign rphase_s = pin_s[SW-6];
  assign strap_s = pin_s[pss_pkg::STRAP_W-1:0];
  // Strap bit 0 tells external clock (1) from crystal (0)
  assign ext_s = strap_s[0];

  typedef struct packed {
    pss_pkg::pss_state_type st;
    logic [pss_pkg::CNT_W-1:0] cnt;
    logic [pss_pkg::CNT_W-1:0] rst_cnt;
    logic xtal_prev;
    logic pgood;
    logic settled;
    logic strap_ok;
    logic [pss_pkg::STRAP_W-1:0] strap;
    logic mgmt;
    logic depth_unit;
    logic fifo_sync;
    logic [1:0] prefill;
    logic rphase;
  } pss_regs_type;

  pss_regs_type r_q;
  pss_regs_type r_d;
  logic all_good;
  logic reset_ok;

  assign all_good = &sup_s;
  // Reset pulses shorter than the minimum low time are ignored
  assign reset_ok = r_q.rst_cnt >= pss_pkg::CNT_W'(RESET_LOW_CYCLES);

  // Sequencer and configuration next state
  always_comb begin
    r_d = r_q;
    r_d.xtal_prev = xtal_s;
    // Low-time counter on the hardware reset pin
    if (!rst_s) begin
      if (!reset_ok) begin
        r_d.rst_cnt = r_q.rst_cnt + 1'b1;
      end
    end else begin
      r_d.rst_cnt = '0;
    end
    // Configuration bits, written by the MAC side
    if (tx_fifo_depth_unit_we) begin
      r_d.depth_unit = tx_fifo_depth_unit_in;
    end
    if (tx_fifo_sync_we) begin
      r_d.fifo_sync = tx_fifo_sync_in;
    end
    // Prefill: bigger when counting bytes on a nibble bus
    if (rmii_mode) begin
      r_d.prefill = pss_pkg::PREFILL_RMII;
    end else if (mii_nibble_mode && r_q.depth_unit) begin
      r_d.prefill = pss_pkg::PREFILL_BYTE;
    end else if (mii_nibble_mode) begin
      r_d.prefill = pss_pkg::PREFILL_NIBBLE;
    end else begin
      r_d.prefill = pss_pkg::PREFILL_NONE;
    end
    // Phase sample frozen while the link is up, so latency never moves
    if (!link_up) begin
      r_d.rphase = rphase_s;
    end
    unique case (r_q.st)
      pss_pkg::ST_POR: begin
        r_d.cnt = '0;
        if (all_good) begin
          r_d.st = pss_pkg::ST_PGOOD_WAIT;
        end
      end
      pss_pkg::ST_PGOOD_WAIT: begin
        // Any supply dropping restarts the count: last riser sets timing
        if (!all_good) begin
          r_d.st = pss_pkg::ST_POR;
        end else if (r_q.cnt >= pss_pkg::CNT_W'(PGOOD_CYCLES - 1)) begin
          r_d.st = pss_pkg::ST_CLK_SETTLE;
          r_d.pgood = 1'b1;
          r_d.cnt = '0;
        end else begin
          r_d.cnt = r_q.cnt + 1'b1;
        end
      end
      pss_pkg::ST_CLK_SETTLE: begin
        // Fixed worst-case wait; no crystal activity check, so a dead crystal
        // still times out and the sequence carries on
        if ((ext_s && r_q.cnt >= pss_pkg::CNT_W'(EXTCLK_CYCLES - 1)) ||
            (!ext_s && r_q.cnt >= pss_pkg::CNT_W'(XTAL_CYCLES - 1))) begin
          r_d.st = pss_pkg::ST_STRAP;
          r_d.settled = 1'b1;
          r_d.cnt = '0;
        end else begin
          r_d.cnt = r_q.cnt + 1'b1;
        end
      end
      pss_pkg::ST_STRAP: begin
        // Captured one cycle after settle, well inside the limit
        r_d.strap = strap_s;
        r_d.strap_ok = 1'b1;
        r_d.st = pss_pkg::ST_MGMT_WAIT;
        r_d.cnt = '0;
      end
      pss_pkg::ST_MGMT_WAIT: begin
        // Short settling hold, bounded by the management deadline
        if (r_q.cnt >= pss_pkg::CNT_W'(MGMT_CYCLES / 1000)) begin
          r_d.mgmt = 1'b1;
          r_d.st = pss_pkg::ST_READY;
        end else begin
          r_d.cnt = r_q.cnt + 1'b1;
        end
      end
      pss_pkg::ST_READY: begin
        r_d.cnt = '0;
      end
      default: begin
        r_d.st = pss_pkg::ST_POR;
      end
    endcase
    // Brown-out or valid hardware reset restarts the sequence
    if (!all_good) begin
      r_d.st = pss_pkg::ST_POR;
      r_d.pgood = 1'b0;
      r_d.settled = 1'b0;
      r_d.strap_ok = 1'b0;
      r_d.mgmt = 1'b0;
      r_d.cnt = '0;
    end else if (!rst_s && reset_ok) begin
      // Jump back only once power is good, so settle never precedes it
      if (r_q.pgood) begin
        r_d.st = pss_pkg::ST_CLK_SETTLE;
        r_d.cnt = '0;
      end
      r_d.settled = 1'b0;
      r_d.strap_ok = 1'b0;
      r_d.mgmt = 1'b0;
      r_d.depth_unit = pss_pkg::DEPTH_UNIT_RST;
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      r_q <= '{st: pss_pkg::ST_POR, cnt: '0, rst_cnt: '0, xtal_prev: 1'b0,
               pgood: 1'b0, settled: 1'b0, strap_ok: 1'b0,
               strap: pss_pkg::STRAP_RST, mgmt: 1'b0,
               depth_unit: pss_pkg::DEPTH_UNIT_RST, fifo_sync: 1'b0,
               prefill: pss_pkg::PREFILL_NONE, rphase: 1'b0};
    end else begin
      r_q <= r_d;
    end
  end

  assign power_good = r_q.pgood;
  assign clock_settled = r_q.settled;
  assign strap_valid = r_q.strap_ok;
  assign strap_cfg = r_q.strap;
  assign mgmt_enable = r_q.mgmt;
  assign tx_fifo_depth_unit = r_q.depth_unit;
  // Low means the FIFO runs asynchronously and absorbs phase offset
  assign tx_fifo_sync = r_q.fifo_sync;
  assign tx_prefill_sel = r_q.prefill;
  assign rmii_phase_held = r_q.rphase;
endmodule
`default_nettype wire
